// >>> src/ebpm_defines.vh
// Constants for the external bus pin multiplexer: register offset, field layout, mode codes.
// Assumes nothing of its surroundings; included by bare name.
`ifndef EBPM_DEFINES_VH
`define EBPM_DEFINES_VH
// Register word address on the CPU I/O port
`define EBPM_SEL_ADDR      16'h1c00
// Writable bits mask (bits 15 and 7-6 reserved)
`define EBPM_WR_MASK       16'h7f3f
`define EBPM_SEL_RESET     16'h0000
// Field positions
`define EBPM_PP_HI         14
`define EBPM_PP_LO         12
`define EBPM_SP1_HI        11
`define EBPM_SP1_LO        10
`define EBPM_SP0_HI        9
`define EBPM_SP0_LO        8
`define EBPM_ADDR_HI       5
`define EBPM_ADDR_LO       0
// Parallel port mode codes
`define EBPM_PP_LCD16      3'h0
`define EBPM_PP_SPI_GIO    3'h1
`define EBPM_PP_LCD8_GIO   3'h2
`define EBPM_PP_LCD8_SPI   3'h3
`define EBPM_PP_LCD8_I2S   3'h4
`define EBPM_PP_LCD8_UART  3'h5
`define EBPM_PP_SPI_I2S    3'h6
// Serial port mode codes
`define EBPM_SP_MMC        2'h0
`define EBPM_SP_I2S        2'h1
`define EBPM_SP_GIO        2'h2
`endif

// >>> src/ebpm_serial_port_mux.v
// Six-pin serial port multiplexer: MMC/SD, I2S plus two GPIO, or six GPIO.
// Assumes a registered mode select; purely combinational routing.
`timescale 1ns/1ps
`include "ebpm_defines.vh"
module ebpm_serial_port_mux (
  // Mode
  input  wire [1:0] mode,
  // Peripheral sides (pin order 5..0)
  input  wire [5:0] mmc_out,
  input  wire [5:0] mmc_oe_n,
  input  wire [3:0] i2s_out,
  input  wire [3:0] i2s_oe_n,
  input  wire [5:0] gio_out,
  input  wire [5:0] gio_oe_n,
  // Pins
  output reg  [5:0] pin_out,
  output reg  [5:0] pin_oe_n
);
  // Route by mode; reserved code releases pins
  always @*
  begin
    case (mode)
      `EBPM_SP_MMC:
      begin
        pin_out  = mmc_out;
        pin_oe_n = mmc_oe_n;
      end
      `EBPM_SP_I2S:
      begin
        // Upper two pins stay GPIO
        pin_out  = {gio_out[5:4], i2s_out};
        pin_oe_n = {gio_oe_n[5:4], i2s_oe_n};
      end
      `EBPM_SP_GIO:
      begin
        pin_out  = gio_out;
        pin_oe_n = gio_oe_n;
      end
      default:
      begin
        // Unsupported code: nothing drives
        pin_out  = 6'h00;
        pin_oe_n = 6'h3f;
      end
    endcase
  end
endmodule // ebpm_serial_port_mux

// >>> src/ebpm_pin_mux.v
// External bus pin multiplexer top: selection register on the CPU I/O port
// and routing of parallel port, two serial ports and upper address pins.
// Assumes a synchronous CPU I/O port with one-cycle read/write strobes.
//
// Notes on behaviour
// - Mode 0: all 21 LCD signals on port
// - Mode 1: SPI7, GPIO6, UART4, I2S2x4
// - Mode 2: LCD8 data plus eight GPIO
// - Mode 3: LCD8, SPI4, I2S3x4
// - Mode 4: LCD8, I2S2x4, UART4
// - Mode 5: LCD8, SPI4, UART4
// - Mode 6: SPI7, I2S2, I2S3, GPIO6
// - Serial port 1 mode 0: MMC/SD1
// - Serial port 1 mode 1: I2S1, GPIO 11:10
// - Serial port 1 mode 2: GPIO 11:6
// - Serial port 0 mode 0: MMC/SD0
// - Serial port 0 mode 1: I2S0, GPIO 5:4
// - Serial port 0 mode 2: GPIO 5:0
// - Each address select bit independent, 1=GPIO
// - Address 20..18 selects at bits 5..3
// - Address 17..15 selects at bits 2..0
// - New routing applies next clock cycle
// - Bits 15, 7-6 read zero, ignore writes
// - Reset clears all mode fields
`timescale 1ns/1ps
`include "ebpm_defines.vh"
module ebpm_pin_mux (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // CPU I/O port
  input  wire [15:0] io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [15:0] io_wdata,
  output reg  [15:0] io_rdata,
  // Routing state view
  output wire [2:0]  parallel_port_route_sel,
  output wire [1:0]  serial_port1_route_sel,
  output wire [1:0]  serial_port0_route_sel,
  // LCD bridge (21 signals)
  input  wire [20:0] lcd_out,
  input  wire [20:0] lcd_oe_n,
  output wire [20:0] lcd_in,
  // SPI (7 signals)
  input  wire [6:0]  spi_out,
  input  wire [6:0]  spi_oe_n,
  output wire [6:0]  spi_in,
  // UART (4 signals)
  input  wire [3:0]  uart_out,
  input  wire [3:0]  uart_oe_n,
  output wire [3:0]  uart_in,
  // I2S2 and I2S3 (4 signals each)
  input  wire [3:0]  i2s2_out,
  input  wire [3:0]  i2s2_oe_n,
  output wire [3:0]  i2s2_in,
  input  wire [3:0]  i2s3_out,
  input  wire [3:0]  i2s3_oe_n,
  output wire [3:0]  i2s3_in,
  // Parallel port GPIO (8 lines)
  input  wire [7:0]  pp_gio_out,
  input  wire [7:0]  pp_gio_oe_n,
  output wire [7:0]  pp_gio_in,
  // Parallel port pins
  input  wire [20:0] pp_pin_in,
  output reg  [20:0] pp_pin_out,
  output reg  [20:0] pp_pin_oe_n,
  // Serial port 1 peripherals and pins
  input  wire [5:0]  mmc1_out,
  input  wire [5:0]  mmc1_oe_n,
  input  wire [3:0]  i2s1_out,
  input  wire [3:0]  i2s1_oe_n,
  output wire [5:0]  sp1_pin_out,
  output wire [5:0]  sp1_pin_oe_n,
  input  wire [5:0]  sp1_pin_in,
  output wire [5:0]  sp1_periph_in,
  // Serial port 0 peripherals and pins
  input  wire [5:0]  mmc0_out,
  input  wire [5:0]  mmc0_oe_n,
  input  wire [3:0]  i2s0_out,
  input  wire [3:0]  i2s0_oe_n,
  output wire [5:0]  sp0_pin_out,
  output wire [5:0]  sp0_pin_oe_n,
  input  wire [5:0]  sp0_pin_in,
  output wire [5:0]  sp0_periph_in,
  // General I/O lines 11..0 for serial ports
  input  wire [11:0] sp_gio_out,
  input  wire [11:0] sp_gio_oe_n,
  // Upper address pins 20..15 and GPIO 26..21
  input  wire [5:0]  ext_mem_address_out,
  input  wire [5:0]  addr_gio_out,
  input  wire [5:0]  addr_gio_oe_n,
  input  wire [5:0]  ext_mem_address_pin_in,
  output wire [5:0]  addr_gio_in,
  output wire [5:0]  ext_mem_address_pin_out,
  output wire [5:0]  ext_mem_address_pin_oe_n
);

  // Selection register, reserved bits held at zero
  reg  [15:0] external_bus_selection;
  wire        sel_hit;              // Address decode
  wire [5:0]  addr_func_sel;        // Per-pin GPIO select
  wire        addr20_pin_func_sel;
  wire        addr19_pin_func_sel;
  wire        addr18_pin_func_sel;
  wire        addr17_pin_func_sel;
  wire        addr16_pin_func_sel;
  wire        addr15_pin_func_sel;

  assign sel_hit = (io_addr == `EBPM_SEL_ADDR);

  // Register write; the new value drives routing from the following cycle
  always @(posedge clk)
  begin
    if (!rst_n)
      external_bus_selection <= `EBPM_SEL_RESET;
    else if (io_wr && sel_hit)
      external_bus_selection <= io_wdata & `EBPM_WR_MASK;
  end

  // Registered read data; unmapped addresses read zero
  always @(posedge clk)
  begin
    if (!rst_n)
      io_rdata <= 16'h0000;
    else if (io_rd && sel_hit)
      io_rdata <= external_bus_selection;
    else if (io_rd)
      io_rdata <= 16'h0000;
  end

  // Field extraction
  assign parallel_port_route_sel = external_bus_selection[`EBPM_PP_HI:`EBPM_PP_LO];
  assign serial_port1_route_sel  = external_bus_selection[`EBPM_SP1_HI:`EBPM_SP1_LO];
  assign serial_port0_route_sel  = external_bus_selection[`EBPM_SP0_HI:`EBPM_SP0_LO];
  assign addr_func_sel           = external_bus_selection[`EBPM_ADDR_HI:`EBPM_ADDR_LO];
  assign addr20_pin_func_sel = addr_func_sel[5];
  assign addr19_pin_func_sel = addr_func_sel[4];
  assign addr18_pin_func_sel = addr_func_sel[3];
  assign addr17_pin_func_sel = addr_func_sel[2];
  assign addr16_pin_func_sel = addr_func_sel[1];
  assign addr15_pin_func_sel = addr_func_sel[0];

  // Parallel port output routing. Pin layout per mode is a fixed packing,
  // low pins first; software gating and peripheral resets around changes
  // are the caller's duty since this mux switches instantly.
  //
  // Pin map of the parallel port, pin 0 first:
  //
  // Mode 0, sixteen-bit LCD
  //   pins 20..0  : LCD bridge signals 20..0
  //
  // Mode 1, SPI, GPIO, UART and I2S2
  //   pins 6..0   : SPI signals 6..0
  //   pins 12..7  : port GPIO 5..0
  //   pins 16..13 : UART signals 3..0
  //   pins 20..17 : I2S2 signals 3..0
  //
  // Mode 2, eight-bit LCD and GPIO
  //   pins 7..0   : LCD pixel data 7..0
  //   pins 15..8  : port GPIO 7..0
  //   pins 20..16 : released
  //
  // Mode 3, eight-bit LCD, SPI and I2S3
  //   pins 7..0   : LCD pixel data 7..0
  //   pins 11..8  : SPI signals 3..0
  //   pins 15..12 : I2S3 signals 3..0
  //   pins 20..16 : released
  //
  // Mode 4, eight-bit LCD, I2S2 and UART
  //   pins 7..0   : LCD pixel data 7..0
  //   pins 11..8  : I2S2 signals 3..0
  //   pins 15..12 : UART signals 3..0
  //   pins 20..16 : released
  //
  // Mode 5, eight-bit LCD, SPI and UART
  //   pins 7..0   : LCD pixel data 7..0
  //   pins 11..8  : SPI signals 3..0
  //   pins 15..12 : UART signals 3..0
  //   pins 20..16 : released
  //
  // Mode 6, SPI, I2S2, I2S3 and GPIO
  //   pins 6..0   : SPI signals 6..0
  //   pins 10..7  : I2S2 signals 3..0
  //   pins 14..11 : I2S3 signals 3..0
  //   pins 20..15 : port GPIO 5..0
  //
  // Code 7 is reserved: every pin released, every input reads zero.
  //
  // Released pins carry a low level behind a high enable so that a pad
  // left floating never shows a stale peripheral value.
  //
  // Serial port pin map, pin 0 first, the same for both ports:
  //
  // Mode 0, memory card
  //   pins 5..0   : card controller signals 5..0
  //
  // Mode 1, I2S and two GPIO
  //   pins 3..0   : I2S signals 3..0
  //   pins 5..4   : top two lines of the port's GPIO group
  //
  // Mode 2, GPIO
  //   pins 5..0   : the port's six GPIO lines
  //
  // Code 3 is reserved and releases the whole port.
  //
  // GPIO groups: serial port 1 owns lines 11..6, serial port 0
  // owns lines 5..0.
  //
  // Upper address pins, one select bit each:
  //   pin 20 : register bit 5, GPIO 26 when set
  //   pin 19 : register bit 4, GPIO 25 when set
  //   pin 18 : register bit 3, GPIO 24 when set
  //   pin 17 : register bit 2, GPIO 23 when set
  //   pin 16 : register bit 1, GPIO 22 when set
  //   pin 15 : register bit 0, GPIO 21 when set
  //
  // Hazards: a change of route is glitch-free only at the register edge,
  // since all muxes below are combinational from one register. A
  // peripheral whose clock still runs during the change may see a few
  // cycles of another peripheral's pin levels; that is why software must
  // gate clocks first and reset the peripherals afterwards.
  //
  // Trade-off: routing stays combinational to keep pin latency at zero
  // cycles; registering the pins would add a cycle to every peripheral.
  //
  // Limitation: the block does not check that software programs the
  // register only once; repeated writes simply take effect each time.
  //
  // Reset: the register clears to zero, so the port comes up as a
  // sixteen-bit LCD port, both serial ports as card ports, and every
  // address pin keeps its memory function.
  always @*
  begin
    case (parallel_port_route_sel)
      `EBPM_PP_LCD16:
      begin
        pp_pin_out  = lcd_out;
        pp_pin_oe_n = lcd_oe_n;
      end
      `EBPM_PP_SPI_GIO:
      begin
        pp_pin_out  = {i2s2_out, uart_out, pp_gio_out[5:0], spi_out};
        pp_pin_oe_n = {i2s2_oe_n, uart_oe_n, pp_gio_oe_n[5:0], spi_oe_n};
      end
      `EBPM_PP_LCD8_GIO:
      begin
        // Five top pins unused here: released
        pp_pin_out  = {5'h00, pp_gio_out, lcd_out[7:0]};
        pp_pin_oe_n = {5'h1f, pp_gio_oe_n, lcd_oe_n[7:0]};
      end
      `EBPM_PP_LCD8_SPI:
      begin
        pp_pin_out  = {5'h00, i2s3_out, spi_out[3:0], lcd_out[7:0]};
        pp_pin_oe_n = {5'h1f, i2s3_oe_n, spi_oe_n[3:0], lcd_oe_n[7:0]};
      end
      `EBPM_PP_LCD8_I2S:
      begin
        pp_pin_out  = {5'h00, uart_out, i2s2_out, lcd_out[7:0]};
        pp_pin_oe_n = {5'h1f, uart_oe_n, i2s2_oe_n, lcd_oe_n[7:0]};
      end
      `EBPM_PP_LCD8_UART:
      begin
        pp_pin_out  = {5'h00, uart_out, spi_out[3:0], lcd_out[7:0]};
        pp_pin_oe_n = {5'h1f, uart_oe_n, spi_oe_n[3:0], lcd_oe_n[7:0]};
      end
      `EBPM_PP_SPI_I2S:
      begin
        pp_pin_out  = {pp_gio_out[5:0], i2s3_out, i2s2_out, spi_out};
        pp_pin_oe_n = {pp_gio_oe_n[5:0], i2s3_oe_n, i2s2_oe_n, spi_oe_n};
      end
      default:
      begin
        // Reserved code: no peripheral may fight the pins
        pp_pin_out  = 21'h000000;
        pp_pin_oe_n = 21'h1fffff;
      end
    endcase
  end

  // Parallel port input fan-out, matching the packing above; unrouted
  // inputs read zero so idle peripherals see a quiet line
  assign lcd_in = (parallel_port_route_sel == `EBPM_PP_LCD16) ? pp_pin_in :
                  ((parallel_port_route_sel >= `EBPM_PP_LCD8_GIO) &&
                   (parallel_port_route_sel <= `EBPM_PP_LCD8_UART)) ? {13'h0000, pp_pin_in[7:0]} : 21'h000000;
  assign spi_in = ((parallel_port_route_sel == `EBPM_PP_SPI_GIO) ||
                   (parallel_port_route_sel == `EBPM_PP_SPI_I2S)) ? pp_pin_in[6:0] :
                  ((parallel_port_route_sel == `EBPM_PP_LCD8_SPI) ||
                   (parallel_port_route_sel == `EBPM_PP_LCD8_UART)) ? {3'h0, pp_pin_in[11:8]} : 7'h00;
  assign uart_in = (parallel_port_route_sel == `EBPM_PP_SPI_GIO)   ? pp_pin_in[16:13] :
                   (parallel_port_route_sel == `EBPM_PP_LCD8_I2S)  ? pp_pin_in[15:12] :
                   (parallel_port_route_sel == `EBPM_PP_LCD8_UART) ? pp_pin_in[15:12] : 4'h0;
  assign i2s2_in = (parallel_port_route_sel == `EBPM_PP_SPI_GIO)   ? pp_pin_in[20:17] :
                   (parallel_port_route_sel == `EBPM_PP_LCD8_I2S)  ? pp_pin_in[11:8] :
                   (parallel_port_route_sel == `EBPM_PP_SPI_I2S)   ? pp_pin_in[10:7] : 4'h0;
  assign i2s3_in = (parallel_port_route_sel == `EBPM_PP_LCD8_SPI)  ? pp_pin_in[15:12] :
                   (parallel_port_route_sel == `EBPM_PP_SPI_I2S)   ? pp_pin_in[14:11] : 4'h0;
  assign pp_gio_in = (parallel_port_route_sel == `EBPM_PP_SPI_GIO)  ? {2'h0, pp_pin_in[12:7]} :
                     (parallel_port_route_sel == `EBPM_PP_LCD8_GIO) ? pp_pin_in[15:8] :
                     (parallel_port_route_sel == `EBPM_PP_SPI_I2S)  ? {2'h0, pp_pin_in[20:15]} : 8'h00;

  // Serial port 1: GPIO 11..6
  ebpm_serial_port_mux u_sp1 (
    .mode     (serial_port1_route_sel),
    .mmc_out  (mmc1_out),
    .mmc_oe_n (mmc1_oe_n),
    .i2s_out  (i2s1_out),
    .i2s_oe_n (i2s1_oe_n),
    .gio_out  (sp_gio_out[11:6]),
    .gio_oe_n (sp_gio_oe_n[11:6]),
    .pin_out  (sp1_pin_out),
    .pin_oe_n (sp1_pin_oe_n)
  );

  // Serial port 0: GPIO 5..0
  ebpm_serial_port_mux u_sp0 (
    .mode     (serial_port0_route_sel),
    .mmc_out  (mmc0_out),
    .mmc_oe_n (mmc0_oe_n),
    .i2s_out  (i2s0_out),
    .i2s_oe_n (i2s0_oe_n),
    .gio_out  (sp_gio_out[5:0]),
    .gio_oe_n (sp_gio_oe_n[5:0]),
    .pin_out  (sp0_pin_out),
    .pin_oe_n (sp0_pin_oe_n)
  );

  // Serial inputs pass to whichever peripheral owns the pins; reserved reads zero
  assign sp1_periph_in = (serial_port1_route_sel == 2'h3) ? 6'h00 : sp1_pin_in;
  assign sp0_periph_in = (serial_port0_route_sel == 2'h3) ? 6'h00 : sp0_pin_in;

  // Upper address pins, each chosen on its own bit; memory address always driven
  assign ext_mem_address_pin_out  = (addr_func_sel & addr_gio_out) |
                                    (~addr_func_sel & ext_mem_address_out);
  assign ext_mem_address_pin_oe_n = addr_func_sel & addr_gio_oe_n;
  assign addr_gio_in              = addr_func_sel & ext_mem_address_pin_in;

endmodule // ebpm_pin_mux

// >>> verification/ebpm_periph_model.sv
// Stand-in for the peripherals and pads around the pin multiplexer.
// Assumes one clock; every pattern flips each cycle so a stale path shows.
`timescale 1ns/1ps
module ebpm_periph_model (
  // Clock
  input  logic        clk,
  // Peripheral outputs, output enables, pad levels
  output logic [95:0] drv,
  output logic [95:0] oen,
  output logic [38:0] pin
);
  logic flip = 1'b0; // Toggles every cycle

  // Inverting each cycle keeps a stuck route from matching by luck
  always @(posedge clk)
  begin
    flip <= ~flip;
  end
  assign drv = {3{32'hc3a596e1}} ^ {96{flip}};
  assign oen = {3{32'h5a0f33cc}} ^ {96{flip}};
  assign pin = {39{flip}} ^ 39'h5b3c96a1e7;
endmodule // ebpm_periph_model

// >>> verification/ebpm_pin_mux_monitor.sv
// Concurrent checks on the pin multiplexer top ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`include "ebpm_defines.vh"
module ebpm_pin_mux_monitor (
  // Clock and reset
  input logic        clk,
  input logic        rst_n,
  // CPU I/O port
  input logic [15:0] io_addr,
  input logic        io_wr,
  input logic        io_rd,
  input logic [15:0] io_wdata,
  input logic [15:0] io_rdata,
  // Route fields
  input logic [2:0]  parallel_port_route_sel,
  input logic [1:0]  serial_port1_route_sel,
  input logic [1:0]  serial_port0_route_sel,
  // Peripherals and pins
  input logic [20:0] lcd_out,
  input logic [20:0] lcd_oe_n,
  input logic [20:0] pp_pin_out,
  input logic [20:0] pp_pin_oe_n,
  input logic [5:0]  mmc1_out,
  input logic [5:0]  sp1_pin_out,
  input logic [11:0] sp_gio_out,
  input logic [5:0]  sp0_pin_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       hit; // Register write this cycle
  logic [6:0] sel; // All route fields
  assign hit = io_wr && io_addr == `EBPM_SEL_ADDR;
  assign sel = {parallel_port_route_sel, serial_port1_route_sel, serial_port0_route_sel};
  // Write taken, then fields follow one edge later
  sequence s_write;
    hit;
  endsequence
  sequence s_new_route;
    sel == $past(io_wdata[14:8]);
  endsequence
  AST_WR_TAKEN: assert property (s_write |=> s_new_route)
    else $error("route fields missed a write");
  AST_HOLD: assert property (!hit |=> $stable(sel))
    else $error("route fields moved without a write");
  AST_RD_MAP: assert property (io_rd && !io_wr && io_addr == `EBPM_SEL_ADDR |=>
    io_rdata[15:6] == {1'b0, sel, 2'b00}) else $error("register read wrong");
  AST_RD_OFF: assert property (io_rd && io_addr != `EBPM_SEL_ADDR |=> io_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_RESET: assert property ($rose(rst_n) |-> sel == 7'h00 && io_rdata == 16'h0000)
    else $error("reset did not clear");
  AST_LCD16: assert property (parallel_port_route_sel == `EBPM_PP_LCD16 |->
    pp_pin_out == lcd_out && pp_pin_oe_n == lcd_oe_n) else $error("parallel port not LCD");
  AST_SP1_MMC: assert property (serial_port1_route_sel == `EBPM_SP_MMC |-> sp1_pin_out == mmc1_out)
    else $error("serial port 1 not MMC");
  AST_SP0_GIO: assert property (serial_port0_route_sel == `EBPM_SP_GIO |-> sp0_pin_out == sp_gio_out[5:0])
    else $error("serial port 0 not GPIO");
  AST_PP_RSV: assert property (parallel_port_route_sel == 3'h7 |-> pp_pin_oe_n == 21'h1fffff)
    else $error("reserved mode drives pins");
endmodule // ebpm_pin_mux_monitor

bind ebpm_pin_mux ebpm_pin_mux_monitor ebpm_pin_mux_monitor_inst (.clk(clk), .rst_n(rst_n),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .parallel_port_route_sel(parallel_port_route_sel), .serial_port1_route_sel(serial_port1_route_sel),
  .serial_port0_route_sel(serial_port0_route_sel), .lcd_out(lcd_out), .lcd_oe_n(lcd_oe_n),
  .pp_pin_out(pp_pin_out), .pp_pin_oe_n(pp_pin_oe_n), .mmc1_out(mmc1_out),
  .sp1_pin_out(sp1_pin_out), .sp_gio_out(sp_gio_out), .sp0_pin_out(sp0_pin_out));

// >>> verification/ebpm_pin_mux_bench.sv
// Self-checking bench for the pin multiplexer: register, routing, reset.
// Assumes the partner model supplies every peripheral and pad input.
`timescale 1ns/1ps
`include "ebpm_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module ebpm_pin_mux_bench;
  logic        clk = 1'b0;        // 100 MHz
  logic        rst_n = 1'b0;      // Sync reset
  logic        io_wr = 1'b0;      // Write strobe
  logic        io_rd = 1'b0;      // Read strobe
  logic [15:0] io_addr = 16'h0000;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic [2:0]  pps;
  logic [1:0]  s1s, s0s;
  logic [95:0] d, o;              // Model outputs and enables
  logic [38:0] p;                 // Model pad levels
  logic [20:0] ppo, ppe, lcd_in;
  logic [5:0]  s1o, s1e, s0o, s0e, ao, ae, agi;
  int          err_total = 0;
  int          n_compared = 0;
  localparam logic [15:0] A = `EBPM_SEL_ADDR;

  always #5 clk = ~clk;
  ebpm_periph_model ebpm_periph_model_inst (.clk(clk), .drv(d), .oen(o), .pin(p));
  ebpm_pin_mux ebpm_pin_mux_inst (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .parallel_port_route_sel(pps),
    .serial_port1_route_sel(s1s), .serial_port0_route_sel(s0s),
    .lcd_out(d[20:0]), .lcd_oe_n(o[20:0]), .lcd_in(lcd_in),
    .spi_out(d[27:21]), .spi_oe_n(o[27:21]), .spi_in(),
    .uart_out(d[31:28]), .uart_oe_n(o[31:28]), .uart_in(),
    .i2s2_out(d[35:32]), .i2s2_oe_n(o[35:32]), .i2s2_in(),
    .i2s3_out(d[39:36]), .i2s3_oe_n(o[39:36]), .i2s3_in(),
    .pp_gio_out(d[47:40]), .pp_gio_oe_n(o[47:40]), .pp_gio_in(),
    .pp_pin_in(p[20:0]), .pp_pin_out(ppo), .pp_pin_oe_n(ppe),
    .mmc1_out(d[53:48]), .mmc1_oe_n(o[53:48]), .i2s1_out(d[57:54]), .i2s1_oe_n(o[57:54]),
    .sp1_pin_out(s1o), .sp1_pin_oe_n(s1e), .sp1_pin_in(p[26:21]), .sp1_periph_in(),
    .mmc0_out(d[63:58]), .mmc0_oe_n(o[63:58]), .i2s0_out(d[67:64]), .i2s0_oe_n(o[67:64]),
    .sp0_pin_out(s0o), .sp0_pin_oe_n(s0e), .sp0_pin_in(p[32:27]), .sp0_periph_in(),
    .sp_gio_out(d[79:68]), .sp_gio_oe_n(o[79:68]), .ext_mem_address_out(d[85:80]),
    .addr_gio_out(d[91:86]), .addr_gio_oe_n(o[91:86]), .ext_mem_address_pin_in(p[38:33]),
    .addr_gio_in(agi), .ext_mem_address_pin_out(ao), .ext_mem_address_pin_oe_n(ae));

  // Expected parallel pins; f fills released pins (0 for data, 1 for enables)
  function automatic logic [20:0] ppx(input logic [2:0] m, input logic [95:0] x, input logic f);
    case (m)
      3'h0: ppx = x[20:0];
      3'h1: ppx = {x[35:32], x[31:28], x[45:40], x[27:21]};
      3'h2: ppx = {{5{f}}, x[47:40], x[7:0]};
      3'h3: ppx = {{5{f}}, x[39:36], x[24:21], x[7:0]};
      3'h4: ppx = {{5{f}}, x[31:28], x[35:32], x[7:0]};
      3'h5: ppx = {{5{f}}, x[31:28], x[24:21], x[7:0]};
      3'h6: ppx = {x[45:40], x[39:36], x[35:32], x[27:21]};
      default: ppx = {21{f}};
    endcase
  endfunction
  // Expected serial pins from MMC, I2S and GPIO group
  function automatic logic [5:0] spx(input logic [1:0] m, input logic [5:0] c, input logic [3:0] s,
    input logic [5:0] g, input logic f);
    case (m)
      2'h0: spx = c;
      2'h1: spx = {g[5:4], s};
      2'h2: spx = g;
      default: spx = {6{f}};
    endcase
  endfunction
  // One register write; routing is settled when this returns
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    #1;
  endtask
  // One register read; data is valid when this returns
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
  endtask
  // Default routing straight after reset
  task automatic t_reset();
    rd(A);
    `CHK(io_rdata, 16'h0000)
    `CHK(ppo, d[20:0])
    `CHK(lcd_in, p[20:0])
    `CHK(ae, 6'h00)
  endtask
  // Every mode code of every field, reserved bits written as ones
  // Model peripherals only replay a pattern that flips each cycle, so gating and resets
  // around each write are void; each pass stands for one post-boot setup
  task automatic t_modes();
    logic [15:0] v;
    for (int k = 0; k < 32; k++)
    begin
      v = {1'b1, k[2:0], k[4:3], ~k[4:3], 2'b11, k[4:0], k[0]};
      wr(A, v);
      `CHK({pps, s1s, s0s}, v[14:8])
      `CHK(ppo, ppx(v[14:12], d, 1'b0))
      `CHK(ppe, ppx(v[14:12], o, 1'b1))
      `CHK(s1o, spx(v[11:10], d[53:48], d[57:54], d[79:74], 1'b0))
      `CHK(s0e, spx(v[9:8], o[63:58], o[67:64], o[73:68], 1'b1))
      `CHK(ao, (d[91:86] & v[5:0]) | (d[85:80] & ~v[5:0]))
      `CHK(ae, o[91:86] & v[5:0])
      `CHK(s1e, spx(v[11:10], o[53:48], o[57:54], o[79:74], 1'b1))
      `CHK(s0o, spx(v[9:8], d[63:58], d[67:64], d[73:68], 1'b0))
      `CHK(agi, v[5:0] & p[38:33])
      `CHK(lcd_in, (v[14:12] == 3'h0) ? p[20:0] : ((v[14:12] >= 3'h2) && (v[14:12] <= 3'h5)) ? {13'h0000, p[7:0]} : 21'h000000)
      rd(A);
      `CHK(io_rdata, v & `EBPM_WR_MASK)
    end
  endtask
  // A neighbouring address neither writes nor reads the register
  task automatic t_unmapped();
    wr(A, 16'h2500);
    wr(A + 16'h0001, 16'h7fff);
    `CHK({pps, s1s, s0s}, 7'h25)
    rd(A + 16'h0001);
    `CHK(io_rdata, 16'h0000)
  endtask
  // Reset in mid-run returns every field to zero
  task automatic t_rereset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(A);
    `CHK(io_rdata, 16'h0000)
    `CHK({pps, s1s, s0s}, 7'h00)
  endtask
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence, reset held for ten cycles
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_unmapped();
    t_rereset();
    finish_test();
  end
  // Hang guard
  initial
  begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule // ebpm_pin_mux_bench
